// [inc/adcfmt_pkg.sv]
package adcfmt_pkg;

	// Serial word layout
	localparam int            SER_WORD_BITS   = 16;
	localparam int            SER_ADDR_BITS   = 7;
	localparam int            SER_DATA_BITS   = 8;

	// Register offsets
	localparam logic [6:0]    RESET_REG_ADDR  = 7'h00;
	localparam logic [6:0]    FORMAT_REG_ADDR = 7'h04;
	localparam logic [7:0]    FORMAT_RESET    = 8'h00;
	localparam int            RESET_BIT_POS   = 7;
	localparam logic [7:0]    FORMAT_WR_MASK  = 8'h3f;

	// Field positions
	localparam int            TEST_SEL_LSB    = 3;
	localparam int            ALT_POL_POS     = 2;
	localparam int            SCRAMBLE_POS    = 1;
	localparam int            SIGNED_POS      = 0;

	// Test pattern codes
	localparam logic [2:0]    TP_OFF          = 3'h0;
	localparam logic [2:0]    TP_ZEROS        = 3'h1;
	localparam logic [2:0]    TP_ONES         = 3'h3;
	localparam logic [2:0]    TP_CHECKER      = 3'h5;
	localparam logic [2:0]    TP_TOGGLE       = 3'h7;

	// Sample word with overrange flag
	typedef struct packed {
		logic        overrange_flag;
		logic [11:0] sample_bits;
	} adcfmt_word_type;

	localparam logic [12:0]   CHECKER_A       = 13'h1555;
	localparam logic [12:0]   CHECKER_B       = 13'h0aaa;
	localparam logic [12:0]   ALL_ONES        = 13'h1fff;
	localparam logic [11:0]   ALT_POL_MASK    = 12'haaa;

endpackage : adcfmt_pkg

// [rtl/adcfmt_top.sv]
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Format register at 04h, bits 7-6 ignored
// - Bits 5-3 select pattern; 000 normal
// - Code 001 drives all outputs zero
// - Code 011 drives all outputs one
// - Code 101 alternates checkerboard words
// - Code 111 alternates all zeros/ones
// - Bit 2 enables alternate bit polarity
// - Bit 1 enables output randomizer
// - Bit 0 selects two's complement coding
// - Alternate polarity forces offset binary
// - Sixteen-bit serial write: R/W, address, data
// - Software reset clears format register
module adcfmt_top
	import adcfmt_pkg::*;
(
	// Clock and reset
	input  wire logic              CLOCK_I,
	input  wire logic              SRST_I,
	// Serial configuration port pins
	input  wire logic              CS_N_I,
	input  wire logic              SCK_I,
	input  wire logic              SDI_I,
	// Raw converter result, one per sample strobe
	input  wire logic              SAMPLE_VALID_I,
	input  wire adcfmt_word_type   SAMPLE_I,
	// Formatted output
	output logic                   WORD_VALID_O,
	output adcfmt_word_type        WORD_O,
	output logic [7:0]             FORMAT_REG_O
);

	// Pin synchronisers
	logic [2:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
	logic       sck_prev_r, sck_prev_nxt;

	always_comb begin
		sync1_nxt    = {CS_N_I, SCK_I, SDI_I};
		sync2_nxt    = sync1_r;
		sck_prev_nxt = sync2_r[1];
	end

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			sync1_r    <= 3'h7;
			sync2_r    <= 3'h7;
			sck_prev_r <= 1'b1;
		end else begin
			sync1_r    <= sync1_nxt;
			sync2_r    <= sync2_nxt;
			sck_prev_r <= sck_prev_nxt;
		end
	end

	logic cs_n, sck_rise, sdi;
	assign cs_n     = sync2_r[2];
	assign sdi      = sync2_r[0];
	assign sck_rise = sync2_r[1] & ~sck_prev_r;

	// Serial shifter; edges after the sixteenth are ignored
	logic [15:0] shift_r, shift_nxt;
	logic [4:0]  count_r, count_nxt;
	logic        done_r, done_nxt;
	logic [7:0]  format_r, format_nxt;
	logic        word_end;

	assign word_end = ~cs_n & sck_rise & (count_r == 5'(SER_WORD_BITS - 1));

	always_comb begin
		shift_nxt  = shift_r;
		count_nxt  = count_r;
		done_nxt   = 1'b0;
		format_nxt = format_r;
		if (cs_n) begin
			count_nxt = 5'h0;
		end else if (sck_rise && count_r < 5'(SER_WORD_BITS)) begin
			shift_nxt = {shift_r[14:0], sdi};
			count_nxt = count_r + 5'h1;
			done_nxt  = word_end;
		end
		// Write only when the R/W bit is low; reads leave the register alone
		if (done_r && !shift_r[15]) begin
			if (shift_r[14:8] == FORMAT_REG_ADDR)
				format_nxt = shift_r[7:0] & FORMAT_WR_MASK;
			else if (shift_r[14:8] == RESET_REG_ADDR && shift_r[RESET_BIT_POS])
				format_nxt = FORMAT_RESET;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			shift_r  <= 16'h0000;
			count_r  <= 5'h0;
			done_r   <= 1'b0;
			format_r <= FORMAT_RESET;
		end else begin
			shift_r  <= shift_nxt;
			count_r  <= count_nxt;
			done_r   <= done_nxt;
			format_r <= format_nxt;
		end
	end

	// Formatting path
	logic [2:0] test_sel;
	logic       alt_pol, scramble, signed_sel;
	assign test_sel   = format_r[TEST_SEL_LSB +: 3];
	assign alt_pol    = format_r[ALT_POL_POS];
	assign scramble   = format_r[SCRAMBLE_POS];
	assign signed_sel = format_r[SIGNED_POS] & ~alt_pol;

	logic            phase_r, phase_nxt;
	logic            valid_r, valid_nxt;
	adcfmt_word_type word_r, word_nxt;
	logic [11:0]     coded;

	always_comb begin
		phase_nxt = phase_r;
		valid_nxt = SAMPLE_VALID_I;
		word_nxt  = word_r;
		coded     = SAMPLE_I.sample_bits;
		if (signed_sel)
			coded[11] = ~coded[11];
		if (scramble)
			coded[11:1] = coded[11:1] ^ {11{coded[0]}};
		if (alt_pol)
			coded = coded ^ ALT_POL_MASK;
		if (SAMPLE_VALID_I) begin
			phase_nxt = ~phase_r;
			case (test_sel)
				TP_OFF:     word_nxt = {SAMPLE_I.overrange_flag, coded};
				TP_ZEROS:   word_nxt = 13'h0000;
				TP_ONES:    word_nxt = ALL_ONES;
				TP_CHECKER: word_nxt = phase_r ? CHECKER_B : CHECKER_A;
				TP_TOGGLE:  word_nxt = phase_r ? ALL_ONES : 13'h0000;
				// Unused codes fall back to normal data
				default:    word_nxt = {SAMPLE_I.overrange_flag, coded};
			endcase
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			phase_r <= 1'b0;
			valid_r <= 1'b0;
			word_r  <= 13'h0000;
		end else begin
			phase_r <= phase_nxt;
			valid_r <= valid_nxt;
			word_r  <= word_nxt;
		end
	end

	assign WORD_VALID_O = valid_r;
	assign WORD_O       = word_r;
	assign FORMAT_REG_O = format_r;

	chk_upper_bits_zero : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		format_r[7:6] == 2'b00)
		else $error("format upper bits set");
	chk_zero_pattern : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && test_sel == TP_ZEROS |=> word_r == 13'h0000)
		else $error("zero pattern wrong");
	chk_ones_pattern : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && test_sel == TP_ONES |=> word_r == ALL_ONES)
		else $error("ones pattern wrong");
	chk_checker_alt : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && test_sel == TP_CHECKER |=> ((word_r == CHECKER_A || word_r == CHECKER_B)
		&& word_r != $past(word_r, 1)) || $past(test_sel, 2) != TP_CHECKER || !$past(valid_nxt, 2))
		else $error("checkerboard not alternating");
	chk_toggle_alt : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && test_sel == TP_TOGGLE |=> word_r == (phase_r ? 13'h0000 : ALL_ONES))
		else $error("toggle pattern wrong");
	chk_normal_pass : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && format_r == 8'h00 |=> word_r == $past(SAMPLE_I))
		else $error("plain data altered");
	chk_signed_msb : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && format_r == 8'h01 |=> word_r.sample_bits[11] == ~$past(SAMPLE_I.sample_bits[11]))
		else $error("two's complement msb wrong");
	chk_altpol_offset : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && format_r == 8'h05
		|=> word_r.sample_bits == ($past(SAMPLE_I.sample_bits) ^ ALT_POL_MASK))
		else $error("alternate polarity coding wrong");
	chk_scramble_xor : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && format_r == 8'h02 |=> word_r.sample_bits[11:1]
		== ($past(SAMPLE_I.sample_bits[11:1]) ^ {11{$past(SAMPLE_I.sample_bits[0])}}))
		else $error("randomizer wrong");
	chk_scramble_lsb : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && format_r == 8'h02 |=> word_r.sample_bits[0] == $past(SAMPLE_I.sample_bits[0]))
		else $error("randomizer touched the lsb");
	// Output strobe timing and held word
	chk_strobe_follows : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I |=> WORD_VALID_O)
		else $error("output strobe missing");
	chk_strobe_quiet : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		!SAMPLE_VALID_I |=> !WORD_VALID_O && $stable(word_r))
		else $error("output changed without a sample");
	chk_flag_passes : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		SAMPLE_VALID_I && test_sel == TP_OFF |=> word_r.overrange_flag == $past(SAMPLE_I.overrange_flag))
		else $error("overrange flag altered");
	// Serial port checks; a cut or stray word must never touch the register
	chk_write_lands : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		done_r && !shift_r[15] && shift_r[14:8] == FORMAT_REG_ADDR
		|=> format_r == ($past(shift_r[7:0]) & FORMAT_WR_MASK))
		else $error("serial write lost");
	chk_soft_reset : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		done_r && shift_r[15:8] == {1'b0, RESET_REG_ADDR} && shift_r[RESET_BIT_POS] |=> format_r == FORMAT_RESET)
		else $error("software reset missed");
	chk_edge_limit : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		count_r <= 5'(SER_WORD_BITS))
		else $error("serial edge count overrun");
	chk_count_clears : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		cs_n |=> count_r == 5'h0)
		else $error("serial count kept after deselect");
	chk_read_ignored : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		done_r && shift_r[15] |=> $stable(format_r))
		else $error("read word changed the register");
	chk_other_addr : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		done_r && !shift_r[15] && shift_r[14:8] != FORMAT_REG_ADDR && shift_r[14:8] != RESET_REG_ADDR
		|=> $stable(format_r))
		else $error("foreign address changed the register");
	chk_no_stray_write : assert property (@(posedge CLOCK_I) disable iff (SRST_I)
		!done_r |=> $stable(format_r))
		else $error("register changed outside a word end");

endmodule : adcfmt_top

`default_nettype wire

// [verification/adcfmt_rx_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Receiving logic: latches each formatted word on its strobe
module adcfmt_rx_model
	import adcfmt_pkg::*;
(
	// Clock
	input  wire logic            clk_i,
	// Formatted stream from the device
	input  wire logic            word_valid_i,
	input  wire adcfmt_word_type word_i,
	// Captured result
	output logic                 got_o,
	output adcfmt_word_type      cap_o
);
	always_ff @(posedge clk_i) begin
		got_o <= word_valid_i;
		if (word_valid_i) begin
			cap_o <= word_i;
		end
	end
endmodule : adcfmt_rx_model
`default_nettype wire

// [verification/adcfmt_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module adcfmt_tb_top;
	import adcfmt_pkg::*;
	logic            clk = 0, srst = 1, cs_n = 1, sck = 0, sdi = 0, sv = 0;
	adcfmt_word_type smp = '0, wout, cap;
	logic            wv, got;
	logic [7:0]      freg, fmt = 8'h00;
	logic [31:0]     r;
	logic [2:0]      codes [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
	int              fail_count = 0, checked = 0, cycles = 0, seed = 85, nsamp = 0, i;
	adcfmt_word_type exp_q [$];
	adcfmt_top dut (.CLOCK_I(clk), .SRST_I(srst), .CS_N_I(cs_n), .SCK_I(sck), .SDI_I(sdi),
		.SAMPLE_VALID_I(sv), .SAMPLE_I(smp), .WORD_VALID_O(wv), .WORD_O(wout), .FORMAT_REG_O(freg));
	adcfmt_rx_model rx (.clk_i(clk), .word_valid_i(wv), .word_i(wout), .got_o(got), .cap_o(cap));
	always #5 clk = ~clk;
	// Whole run needs about 6400 cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	task cmp_word(input adcfmt_word_type e, input adcfmt_word_type s);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR word exp %h seen %h", e, s);
		end
	endtask : cmp_word
	task cmp_reg(input logic [7:0] e);
		checked++;
		if (freg !== e) begin
			fail_count++;
			$display("ERROR format_reg exp %h seen %h", e, freg);
		end
	endtask : cmp_reg
	// Words still queued at the end mean the output strobe went missing
	task cmp_left(input int s);
		checked++;
		if (s != 0) begin
			fail_count++;
			$display("ERROR pending_words exp 0 seen %0d", s);
		end
	endtask : cmp_left
	// Coding order: signed flip, scrambler, then polarity mask
	function automatic adcfmt_word_type fmt_exp(input adcfmt_word_type s, input logic [7:0] f, input int ph);
		adcfmt_word_type w;
		w = s;
		case (f[5:3])
			3'h1: w = '0;
			3'h3: w = 13'h1fff;
			3'h5: w = ph ? 13'h0aaa : 13'h1555;
			3'h7: w = ph ? 13'h1fff : 13'h0000;
			default: begin
				if (f[0] && !f[2]) w.sample_bits[11] = ~w.sample_bits[11];
				if (f[1]) w.sample_bits[11:1] ^= {11{w.sample_bits[0]}};
				if (f[2]) w.sample_bits ^= 12'haaa;
			end
		endcase
		return w;
	endfunction : fmt_exp
	// SCK levels last 4 clocks, above the synchroniser minimum of 3
	task spi_write(input logic [15:0] w);
		int k;
		@(negedge clk) cs_n = 0;
		for (k = 15; k >= 0; k--) begin
			sdi = w[k];
			sck = 0;
			repeat (4) @(negedge clk);
			sck = 1;
			repeat (4) @(negedge clk);
		end
		sck = 0;
		repeat (4) @(negedge clk);
		cs_n = 1;
		repeat (8) @(negedge clk);
	endtask : spi_write
	task send_burst(input int n);
		repeat (n) begin
			@(negedge clk);
			r = $random(seed);
			sv = 1;
			smp = r[12:0];
			exp_q.push_back(fmt_exp(r[12:0], fmt, nsamp % 2));
			nsamp++;
		end
		@(negedge clk) sv = 0;
	endtask : send_burst
	always @(negedge clk) begin
		if (got === 1'b1) cmp_word(exp_q.pop_front(), cap);
	end
	initial begin
		repeat (6) @(negedge clk);
		srst = 0;
		cmp_reg(8'h00);
		spi_write({1'b0, 7'h04, 8'hff});
		fmt = 8'h3f;
		cmp_reg(fmt);
		for (i = 0; i < 40; i++) begin
			fmt = {2'b00, codes[i / 8], 3'(i)};
			r = $random(seed);
			spi_write({1'b0, 7'h04, r[1:0], fmt[5:0]});
			cmp_reg(fmt);
			send_burst(3);
		end
		spi_write({1'b1, 7'h04, 8'h00});
		cmp_reg(fmt);
		spi_write({1'b0, 7'h05, 8'h00});
		cmp_reg(fmt);
		spi_write({1'b0, 7'h00, 8'h80});
		fmt = 8'h00;
		cmp_reg(fmt);
		send_burst(4);
		repeat (6) @(negedge clk);
		cmp_left(exp_q.size());
		end_of_test();
	end
endmodule : adcfmt_tb_top
`default_nettype wire
